// ### pkg/ecp_pkg.sv
package ecp_pkg;

  // Register map, byte offsets on the plain register port
  localparam int         REG_AW     = 2;
  localparam logic [1:0] OFS_CTRL   = 2'h0;
  localparam logic [1:0] OFS_CCL    = 2'h1;
  localparam logic [1:0] OFS_CCH    = 2'h2;
  localparam logic [1:0] OFS_FLAG   = 2'h3;

  // Reset values and writable bits of the registers
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CTRL_WMASK = 8'hBF;
  localparam logic [7:0]  CC_RST     = 8'h00;
  localparam logic [15:0] CAP_RST    = 16'h0000;
  localparam logic [9:0]  DUTY_RST   = 10'h000;
  localparam int          FLAG_BIT   = 0;

  // Mode select field codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_CMP_TGL  = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC = 4'hB;
  localparam logic [1:0] GRP_CAP       = 2'h1;
  localparam logic [1:0] GRP_PWM       = 2'h3;

  // Capture prescale terminal counts
  localparam logic [3:0] PSC_LAST_4  = 4'h3;
  localparam logic [3:0] PSC_LAST_16 = 4'hF;
  localparam logic [3:0] PSC_ZERO    = 4'h0;

  // Dead band in mclk cycles, less one: both outputs idle for this value plus one
  localparam int         DEAD_BAND_DEF = 4;

  // Control register fields
  typedef struct packed {
    logic       ocfg;
    logic       rsvd;
    logic [1:0] dlb;
    logic [3:0] mode;
  } ecp_ctrl_t;

  // One pin as output value and active-low output enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } ecp_pin_t;

  // Dead band sequencing
  typedef enum logic {DB_WAIT, DB_DRIVE} ecp_db_t;

  function automatic logic is_capture(input logic [3:0] mode);
    return mode[3:2] == GRP_CAP;
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    return (mode == MODE_CMP_TGL) || (mode[3:2] == 2'h2);
  endfunction

endpackage

// ### rtl/ecp_capt_det.sv
`timescale 1ns/1ns
module ecp_capt_det import ecp_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Control
  input  wire logic       clr,
  input  wire logic [3:0] mode,
  // Event pin level and result
  input  wire logic       pin,
  output logic            strobe
);

  logic       s1_q, s1_d;
  logic       s2_q, s2_d;
  logic       prev_q, prev_d;
  logic [3:0] psc_q, psc_d;
  logic       stb_q, stb_d;
  logic       rise;
  logic       fall;

  // Edges seen only after the second stage, at most one strobe per edge
  always_comb begin
    s1_d   = pin;
    s2_d   = s1_q;
    prev_d = s2_q;
    rise   = s2_q & ~prev_q;
    fall   = ~s2_q & prev_q;
    psc_d  = psc_q;
    stb_d  = 1'b0;
    if (clr) begin
      psc_d = PSC_ZERO;
    end else begin
      case (mode)
        MODE_CAP_FALL: stb_d = fall;
        MODE_CAP_RISE: stb_d = rise;
        MODE_CAP_R4: begin
          if (rise) begin
            stb_d = (psc_q[1:0] == PSC_LAST_4[1:0]);
            psc_d = psc_q + 4'h1;
          end
        end
        MODE_CAP_R16: begin
          if (rise) begin
            stb_d = (psc_q == PSC_LAST_16);
            psc_d = psc_q + 4'h1;
          end
        end
        default: stb_d = 1'b0;
      endcase
    end
  end

  // Prescaler survives prescale changes on purpose
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
      psc_q  <= PSC_ZERO;
      stb_q  <= 1'b0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      prev_q <= prev_d;
      psc_q  <= psc_d;
      stb_q  <= stb_d;
    end
  end

  assign strobe = stb_q;

endmodule

// ### rtl/ecp_top.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module ecp_top import ecp_pkg::*; #(
  parameter int DEAD_CYCLES = DEAD_BAND_DEF
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Time base timer and PWM period timer
  input  wire logic [15:0]       tb_value,
  input  wire logic              tb_tick,
  output logic                   tb_clear,
  input  wire logic [9:0]        pwm_count,
  input  wire logic              pwm_period_start,
  // Converter
  input  wire logic              adc_enabled,
  output logic                   adc_start,
  output logic                   special_event,
  // Pins
  input  wire logic              event_pin_in,
  input  wire logic              pin_direction_bit,
  output ecp_pin_t               pri_pin,
  output ecp_pin_t               sec_pin,
  // Flag
  output logic                   unit_event_flag
);

  localparam logic [7:0] DB_LOAD = 8'(DEAD_CYCLES);

  ecp_ctrl_t   ctrl_q, ctrl_d;
  logic [7:0]  ccl_q, ccl_d;
  logic [7:0]  cch_q, cch_d;
  logic        flag_q, flag_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        latch_q, latch_d;
  logic        match_q, match_d;
  logic        pend_q, pend_d;
  logic        adc_q, adc_d;
  logic        spec_q, spec_d;
  logic [9:0]  duty_q, duty_d;
  logic        pon_q, pon_d;
  ecp_db_t     db_q, db_d;
  logic [7:0]  dbc_q, dbc_d;
  logic        pri_o_q, pri_o_d;
  logic        sec_o_q, sec_o_d;
  logic        cap_stb;
  logic        unit_off;
  logic        pwm_mode;
  logic        cmp_mode;
  logic        match;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_ccl;
  logic        wr_cch;
  logic        wr_flag;
  logic        pri_claim;
  logic        sec_claim;
  logic        pwm_on;
  logic        pri_act;
  logic        sec_act;

  // Decoded mode groups
  assign unit_off = (ctrl_q.mode == MODE_OFF);
  assign pwm_mode = (ctrl_q.mode[3:2] == GRP_PWM);
  assign cmp_mode = is_compare(ctrl_q.mode);

  // Address decode for writes
  always_comb begin
    wr_ctrl = 1'b0;
    wr_ccl  = 1'b0;
    wr_cch  = 1'b0;
    wr_flag = 1'b0;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && reg_addr == OFS_CCL) begin
      wr_ccl = 1'b1;
    end else if (reg_wr && reg_addr == OFS_CCH) begin
      wr_cch = 1'b1;
    end else if (reg_wr && reg_addr == OFS_FLAG) begin
      wr_flag = 1'b1;
    end
  end

  // Capture path; pin is the wire level, so port writes capture too
  ecp_capt_det u_capt (
    .mclk   (mclk),
    .srst   (srst),
    .clr    (!is_capture(ctrl_q.mode)),
    .mode   (ctrl_q.mode),
    .pin    (event_pin_in),
    .strobe (cap_stb)
  );

  // Compare against the time base timer, edge of match only
  assign match = (tb_value == {cch_q, ccl_q});
  assign hit   = match & ~match_q & cmp_mode;

  // Register file, capture load and event flag
  always_comb begin
    ctrl_d = ctrl_q;
    ccl_d  = ccl_q;
    cch_d  = cch_q;
    flag_d = flag_q;
    if (wr_ctrl) begin
      ctrl_d = ecp_ctrl_t'(reg_wdata & CTRL_WMASK);
    end
    if (wr_ccl) begin
      ccl_d = reg_wdata;
    end
    if (wr_cch) begin
      cch_d = reg_wdata;
    end
    // Capture beats a same-cycle software write; old value is lost
    if (cap_stb) begin
      {cch_d, ccl_d} = tb_value;
    end
    if (wr_flag && !reg_wdata[FLAG_BIT]) begin
      flag_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (cap_stb || hit) begin
      flag_d = 1'b1;
    end
  end

  // Read data stands in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd && reg_addr == OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (reg_rd && reg_addr == OFS_CCL) begin
      rdata_d = ccl_q;
    end else if (reg_rd && reg_addr == OFS_CCH) begin
      rdata_d = cch_q;
    end else if (reg_rd && reg_addr == OFS_FLAG) begin
      rdata_d = {7'h00, flag_q};
    end
  end

  // Compare latch, special event and pending timer reset
  always_comb begin
    latch_d = latch_q;
    match_d = match;
    pend_d  = pend_q;
    adc_d   = 1'b0;
    spec_d  = 1'b0;
    if (hit) begin
      case (ctrl_q.mode)
        MODE_CMP_TGL:  latch_d = ~latch_q;
        MODE_CMP_SET:  latch_d = 1'b1;
        MODE_CMP_CLR:  latch_d = 1'b0;
        MODE_CMP_SPEC: begin
          spec_d = 1'b1;
          adc_d  = adc_enabled;
          pend_d = 1'b1;
        end
        default:       latch_d = latch_q;
      endcase
    end
    // Reset waits for the timer's next tick, dropped if match goes
    if (pend_q && (tb_tick || !match)) begin
      pend_d = 1'b0;
    end
    if (ctrl_q.mode != MODE_CMP_SPEC) begin
      pend_d = 1'b0;
    end
    if (ctrl_q == ecp_ctrl_t'(CTRL_RST)) begin
      latch_d = 1'b0;
    end
    if (unit_off) begin
      latch_d = 1'b0;
      pend_d  = 1'b0;
    end
  end

  // Only a timer clear leaves here; overflow flag is never touched
  assign tb_clear = pend_q & tb_tick & match;

  // PWM duty and dead band
  always_comb begin
    duty_d = duty_q;
    pon_d  = pon_q;
    db_d   = db_q;
    dbc_d  = dbc_q;
    if (!pwm_mode || pwm_period_start) begin
      duty_d = {ccl_q, ctrl_q.dlb};
    end
    pon_d = pwm_mode & (pwm_count < duty_q);
    case (db_q)
      DB_WAIT: begin
        if (dbc_q == 8'h00) begin
          db_d = DB_DRIVE;
        end else begin
          dbc_d = dbc_q - 8'h01;
        end
      end
      DB_DRIVE: db_d = DB_DRIVE;
      default:  db_d = DB_WAIT;
    endcase
    // In half-bridge, each change of drive side idles both outputs for the dead band
    if (pon_d != pon_q) begin
      db_d  = DB_WAIT;
      dbc_d = DB_LOAD;
    end
    if (unit_off || !pwm_mode) begin
      duty_d = DUTY_RST;
      db_d   = DB_WAIT;
      dbc_d  = DB_LOAD;
    end
  end

  assign pwm_on = pon_q;

  // Half-bridge needs dead band; single output follows duty directly
  always_comb begin
    if (ctrl_q.ocfg) begin
      pri_act = pwm_on & (db_q == DB_DRIVE);
      sec_act = ~pwm_on & (db_q == DB_DRIVE);
    end else begin
      pri_act = pwm_on;
      sec_act = 1'b0;
    end
  end

  // Pin values; config bit only matters in PWM
  always_comb begin
    if (pwm_mode) begin
      pri_o_d = pri_act ^ ctrl_q.mode[1];
      sec_o_d = sec_act ^ ctrl_q.mode[0];
    end else begin
      pri_o_d = latch_q;
      sec_o_d = 1'b0;
    end
  end

  // Pin ownership; capture, 1010 and 1011 never drive the pin
  assign pri_claim = pwm_mode | (cmp_mode & (ctrl_q.mode != MODE_CMP_SWI)
                     & (ctrl_q.mode != MODE_CMP_SPEC));
  assign sec_claim = pwm_mode & ctrl_q.ocfg;

  // State registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q  <= ecp_ctrl_t'(CTRL_RST);
      ccl_q   <= CC_RST;
      cch_q   <= CC_RST;
      flag_q  <= 1'b0;
      rdata_q <= 8'h00;
      latch_q <= 1'b0;
      match_q <= 1'b0;
      pend_q  <= 1'b0;
      adc_q   <= 1'b0;
      spec_q  <= 1'b0;
      duty_q  <= DUTY_RST;
      pon_q   <= 1'b0;
      db_q    <= DB_WAIT;
      dbc_q   <= DB_LOAD;
      pri_o_q <= 1'b0;
      sec_o_q <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      ccl_q   <= ccl_d;
      cch_q   <= cch_d;
      flag_q  <= flag_d;
      rdata_q <= rdata_d;
      latch_q <= latch_d;
      match_q <= match_d;
      pend_q  <= pend_d;
      adc_q   <= adc_d;
      spec_q  <= spec_d;
      duty_q  <= duty_d;
      pon_q   <= pon_d;
      db_q    <= db_d;
      dbc_q   <= dbc_d;
      pri_o_q <= pri_o_d;
      sec_o_q <= sec_o_d;
    end
  end

  // Outputs; direction bit set to input still keeps the primary pin off, not the secondary
  assign reg_rdata       = rdata_q;
  assign adc_start       = adc_q;
  assign special_event   = spec_q;
  assign unit_event_flag = flag_q;
  assign pri_pin.o       = pri_o_q;
  assign pri_pin.oe_n    = ~pri_claim | pin_direction_bit;
  assign sec_pin.o       = sec_o_q;
  assign sec_pin.oe_n    = ~sec_claim;

endmodule

// ### verification/ecp_src_model.sv
`timescale 1ns/1ns
module ecp_src_model import ecp_pkg::*; (
  // Clock and bench controls
  input wire logic        mclk,
  input wire logic        run,
  input wire logic        ld,
  input wire logic [15:0] ld_val,
  input wire logic        lvl,
  // Unit side
  input wire logic        tb_clear,
  input wire ecp_pin_t    pri_pin,
  output logic [15:0]     tb_value,
  output logic            tb_tick,
  output logic            event_pin_in
);
  logic ph_q = 1'b0;

  // Timer clock edge every second mclk; a granted clear wins over counting
  always_ff @(posedge mclk) begin
    ph_q <= !ph_q;
    if (ld) tb_value <= ld_val;
    else if (ph_q && tb_clear) tb_value <= 16'h0000;
    else if (ph_q && run) tb_value <= tb_value + 16'h0001;
  end
  assign tb_tick = ph_q;

  // A driven pin overrides the source, so port writes still make edges
  assign event_pin_in = pri_pin.oe_n ? lvl : pri_pin.o;
endmodule

// ### verification/ecp_sva.sv
`timescale 1ns/1ns
module ecp_sva import ecp_pkg::*; (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              srst,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // Timer and converter
  input wire logic [15:0]       tb_value,
  input wire logic              tb_tick,
  input wire logic              tb_clear,
  input wire logic              adc_enabled,
  input wire logic              adc_start,
  input wire logic              special_event,
  // Pins and flag
  input wire logic              event_pin_in,
  input wire ecp_pin_t          pri_pin,
  input wire ecp_pin_t          sec_pin,
  input wire logic              unit_event_flag
);
  ecp_ctrl_t   ctrl_q;
  ecp_ctrl_t   ctrl_d;
  logic [15:0] cc_q;
  logic [15:0] cc_d;
  logic        hit;
  logic        hit_q;

  // Shadow of software writes; captures not mirrored, so trusted in compare only
  always_comb begin
    ctrl_d = ctrl_q;
    cc_d   = cc_q;
    if (reg_wr && reg_addr == OFS_CTRL) ctrl_d = reg_wdata & CTRL_WMASK;
    if (reg_wr && reg_addr == OFS_CCL) cc_d[7:0] = reg_wdata;
    if (reg_wr && reg_addr == OFS_CCH) cc_d[15:8] = reg_wdata;
    hit = (tb_value == cc_q);
  end

  // Shadow registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      cc_q   <= {CC_RST, CC_RST};
      hit_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cc_q   <= cc_d;
      hit_q  <= hit;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_bit6_zero: assert property (reg_rd && reg_addr == OFS_CTRL |=> !reg_rdata[6])
    else $error("control bit 6 read as one");
  a_flag_sticky: assert property (unit_event_flag && !(reg_wr && reg_addr == OFS_FLAG)
    |=> unit_event_flag) else $error("event flag dropped by hardware");
  a_sec_port: assert property (ctrl_q.mode[3:2] != GRP_PWM |-> sec_pin.oe_n)
    else $error("secondary pin driven outside PWM");
  a_rise_capt: assert property (ctrl_q.mode == MODE_CAP_RISE && $rose(event_pin_in)
    && !unit_event_flag |-> ##[1:6] unit_event_flag) else $error("rising edge not captured");
  a_spec_fire: assert property (ctrl_q.mode == MODE_CMP_SPEC && hit && !hit_q
    |=> special_event && adc_start == $past(adc_enabled)) else $error("special event missing");
  a_clear_cause: assert property (tb_clear |-> tb_tick && hit)
    else $error("timer reset without match at tick");
  a_adc_cause: assert property (adc_start |-> special_event && $past(adc_enabled))
    else $error("conversion start without cause");
  a_zero_low: assert property (reg_wr && reg_addr == OFS_CTRL && reg_wdata == 8'h00
    |=> ##2 !pri_pin.o) else $error("compare latch not forced low");
  a_swi_still: assert property (ctrl_q.mode == MODE_CMP_SWI
    && $past(ctrl_q.mode, 3) == MODE_CMP_SWI |-> $stable(pri_pin.o))
    else $error("pin moved in flag-only mode");
endmodule

bind ecp_top ecp_sva u_sva (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tb_value, .tb_tick, .tb_clear, .adc_enabled, .adc_start, .special_event,
  .event_pin_in, .pri_pin, .sec_pin, .unit_event_flag);

// ### verification/tb.sv
`timescale 1ns/1ns
module tb import ecp_pkg::*;;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_rdata;
  logic [15:0]       tb_value;
  logic              tb_tick;
  logic              tb_clear;
  logic [9:0]        pwm_count = 10'h000;
  logic              pwm_period_start = 1'b0;
  logic              adc_enabled = 1'b0;
  logic              adc_start;
  logic              special_event;
  logic              event_pin_in;
  logic              pin_direction_bit = 1'b1;
  ecp_pin_t          pri_pin;
  ecp_pin_t          sec_pin;
  logic              unit_event_flag;
  logic              run = 1'b0;
  logic              ld = 1'b0;
  logic [15:0]       ld_val = 16'h0000;
  logic              lvl = 1'b0;
  int                err_total = 0;
  int                checked = 0;
  int                seed = 32'h4A19;
  logic [15:0]       v;
  logic [15:0]       c;
  logic [3:0]        m;

  // Design with short dead band
  ecp_top #(.DEAD_CYCLES(1)) uut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tb_value(tb_value), .tb_tick(tb_tick), .tb_clear(tb_clear), .pwm_count(pwm_count),
    .pwm_period_start(pwm_period_start), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .special_event(special_event), .event_pin_in(event_pin_in),
    .pin_direction_bit(pin_direction_bit), .pri_pin(pri_pin), .sec_pin(sec_pin),
    .unit_event_flag(unit_event_flag));

  // Timer and event source
  ecp_src_model src (.mclk(mclk), .run(run), .ld(ld), .ld_val(ld_val), .lvl(lvl),
    .tb_clear(tb_clear), .pri_pin(pri_pin), .tb_value(tb_value), .tb_tick(tb_tick),
    .event_pin_in(event_pin_in));

  // 100 MHz clock
  initial begin
    forever #5 mclk = !mclk;
  end

  task final_report;
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask

  // Long enough for sync, strobe and load
  task pin_to(input logic b);
    @(posedge mclk);
    lvl <= b;
    repeat (6) @(posedge mclk);
  endtask

  task setv(input logic [15:0] x);
    @(posedge mclk);
    ld     <= 1'b1;
    ld_val <= x;
    @(posedge mclk);
    ld <= 1'b0;
  endtask

  task pstart;
    @(posedge mclk);
    pwm_period_start <= 1'b1;
    @(posedge mclk);
    pwm_period_start <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rchk(OFS_CTRL, CTRL_RST);
    rchk(OFS_FLAG, 8'h00);
    wr(OFS_CTRL, 8'hFF);
    rchk(OFS_CTRL, 8'hBF);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, {4'h0, MODE_CAP_RISE});
    wr(OFS_FLAG, 8'h00);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      setv(16'($random(seed)));
      pin_to(1'b1);
      pin_to(1'b0);
      setv(c);
      pin_to(1'b1);
      pin_to(1'b0);
      rchk(OFS_CCL, c[7:0]);
      rchk(OFS_CCH, c[15:8]);
      rchk(OFS_FLAG, 8'h01);
      wr(OFS_FLAG, 8'h00);
      rchk(OFS_FLAG, 8'h00);
    end
    // Falling mode ignores rises
    wr(OFS_CTRL, 8'h00);
    pin_to(1'b1);
    wr(OFS_CTRL, {4'h0, MODE_CAP_FALL});
    wr(OFS_FLAG, 8'h00);
    pin_to(1'b0);
    rchk(OFS_FLAG, 8'h01);
    wr(OFS_FLAG, 8'h00);
    pin_to(1'b1);
    rchk(OFS_FLAG, 8'h00);
    // Prescaled capture fires on the last edge only
    for (int j = 0; j < 2; j++) begin
      wr(OFS_CTRL, 8'h00);
      pin_to(1'b0);
      wr(OFS_CTRL, {4'h0, (j ? MODE_CAP_R16 : MODE_CAP_R4)});
      wr(OFS_FLAG, 8'h00);
      repeat (j ? 15 : 3) begin
        pin_to(1'b1);
        pin_to(1'b0);
      end
      rchk(OFS_FLAG, 8'h00);
      pin_to(1'b1);
      rchk(OFS_FLAG, 8'h01);
    end
    // Compare actions on a running timer
    wr(OFS_CTRL, 8'h00);
    pin_direction_bit <= 1'b0;
    run <= 1'b1;
    v = 16'($random(seed)) | 16'h0100;
    wr(OFS_CCL, v[7:0]);
    wr(OFS_CCH, v[15:8]);
    for (int k = 0; k < 5; k++) begin
      m = (k == 0) ? MODE_CMP_TGL : (k == 1) ? MODE_CMP_CLR : (k == 2) ? MODE_CMP_SET
        : (k == 3) ? MODE_CMP_SWI : MODE_CMP_SPEC;
      adc_enabled <= 1'($random(seed));
      wr(OFS_CTRL, {4'h0, m});
      wr(OFS_FLAG, 8'h00);
      setv(v - 16'h0003);
      for (int i = 0; i < 40 && special_event !== 1'b1 && unit_event_flag !== 1'b1; i++) begin
        @(posedge mclk);
        #1;
      end
      if (k == 4) chk("adc_start", {15'h0, adc_enabled}, {15'h0, adc_start});
      if (unit_event_flag !== 1'b1 && special_event !== 1'b1) begin
        err_total++;
        $display("[FAIL] match wait expected 1 seen 0");
        final_report;
      end
      // Timer runs on, so its reset is only visible on the tick after the match
      if (k == 4) begin
        @(posedge mclk);
        #1 chk("timer", 16'h0000, tb_value);
      end
      repeat (4) @(posedge mclk);
      chk("pri_out", {15'h0, k != 1}, {15'h0, pri_pin.o});
      chk("pri_oe_n", {15'h0, k > 2}, {15'h0, pri_pin.oe_n});
      rchk(OFS_FLAG, 8'h01);
    end
    wr(OFS_CTRL, 8'h00);
    repeat (4) @(posedge mclk);
    chk("pri_out", 16'h0000, {15'h0, pri_pin.o});
    // Idle PWM level and pin use per mode
    run <= 1'b0;
    wr(OFS_CCL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, {i[2], 3'b000, 2'b11, i[1:0]});
      pstart;
      chk("pri_out", {15'h0, i[1]}, {15'h0, pri_pin.o});
      chk("sec_oe_n", {15'h0, !i[2]}, {15'h0, sec_pin.oe_n});
      if (i[2]) chk("sec_out", {15'h0, !i[0]}, {15'h0, sec_pin.o});
    end
    // Ten-bit duty of 7
    wr(OFS_CCL, 8'h01);
    wr(OFS_CTRL, 8'h3C);
    pwm_count <= 10'h006;
    pstart;
    chk("pri_out", 16'h0001, {15'h0, pri_pin.o});
    pwm_count <= 10'h007;
    repeat (4) @(posedge mclk);
    chk("pri_out", 16'h0000, {15'h0, pri_pin.o});
    // Reset in mid-run returns the control register to its idle value
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rchk(OFS_CTRL, CTRL_RST);
    chk("sec_oe_n", 16'h0001, {15'h0, sec_pin.oe_n});
    final_report;
  end
endmodule
